// ---- btc_pkg.sv ----
`default_nettype none
package btc_pkg;
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFF_OPERAND = 8'h00;
	localparam logic [7:0] OFF_INSN = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_REG_SEL = 8'h0c;
	localparam logic [7:0] OFF_REG_DATA = 8'h10;
	localparam logic [7:0] OFF_STACK_PTR = 8'h14;
	localparam logic [7:0] OFF_CODE_LOAD = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// status_flags bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] SP_RESET = 16'h025f;
	localparam logic [15:0] REG_TOP = 16'h0020;
	localparam logic [15:0] IO_TOP = 16'h0060;
	localparam logic [4:0] REG_X = 5'h1a;
	localparam logic [4:0] REG_Y = 5'h1c;
	localparam logic [4:0] REG_Z = 5'h1e;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [1:0] PTR_NONE = 2'h0;
	localparam logic [1:0] PTR_X = 2'h1;
	localparam logic [1:0] PTR_Y = 2'h2;
	localparam logic [1:0] PTR_Z = 2'h3;
	typedef enum {ex_idle, ex_run, ex_hold} btc_state_t;
	typedef enum logic [4:0] {
		op_nop, op_sshr, op_swap, op_flag, op_to_tflag, op_from_tflag, op_mov, op_pair, op_ldi,
		op_load, op_store, op_code, op_in, op_out, op_push, op_pop,
		op_sleep, op_wdog, op_break, op_bad
	} btc_op_t;
	typedef struct packed {
		btc_op_t op;
		logic [4:0] rd;
		logic [4:0] rr;
		logic [2:0] bit_sel;
		logic setv;
		logic [7:0] imm;
		logic [5:0] io;
		logic [1:0] ptr;
		logic inc;
		logic dec;
		logic abs;
		logic [5:0] disp;
		logic [1:0] cycles;
	} btc_dec_t;
endpackage
`default_nettype wire

// ---- btc_core.sv ----
// Function
// - bit store copies register bit into T
// - bit load writes T into register bit
// - set/clear overflow, one cycle, alone
// - set/clear half carry, one cycle, alone
// - set/clear signed flag, one cycle, alone
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - displacement load from Y/Z plus offset
// - absolute load, two cycles, no flags
// - post-increment store writes then bumps pointer
// - pre-decrement store drops pointer then writes
// - displacement store to Y/Z plus offset
// - absolute store, two cycles, no flags
// - code read via Z, three cycles
// - push stores register, two cycles
// - pop loads register, two cycles
// - sleep issues in one cycle, no flags
// - watchdog restart, one cycle, no flags
// - break only signals debug, no flags
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module btc_core #(
	parameter int DMEM_DEPTH = 512,
	parameter int CMEM_DEPTH = 1024
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [btc_pkg::AXI_AW-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [btc_pkg::AXI_AW-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic sleep_pulse,
	output logic wdt_restart,
	output logic debug_break
);
	import btc_pkg::*;
	localparam int DW = $clog2(DMEM_DEPTH);
	localparam int CW = $clog2(CMEM_DEPTH);

	logic [7:0] rf [32];
	logic [7:0] io_mem [64];
	logic [7:0] sram [DMEM_DEPTH];
	logic [15:0] cmem [CMEM_DEPTH];
	btc_state_t state;
	logic [1:0] cnt;
	logic [15:0] insn;
	logic [15:0] operand;
	logic [4:0] reg_sel;
	logic [7:0] flags;
	logic [15:0] sp;
	logic sleeping;
	logic illegal;
	btc_dec_t dec;

	function automatic logic [4:0] ptr_base(input logic [1:0] p);
		case (p)
			PTR_X: ptr_base = REG_X;
			PTR_Y: ptr_base = REG_Y;
			default: ptr_base = REG_Z;
		endcase
	endfunction

	function automatic btc_dec_t decode(input logic [15:0] w);
		btc_dec_t d;
		d = '0;
		d.op = op_bad;
		d.rd = w[8:4];
		d.rr = {w[9], w[3:0]};
		d.bit_sel = w[2:0];
		d.imm = {w[11:8], w[3:0]};
		d.io = {w[10:9], w[3:0]};
		d.disp = {w[13], w[11:10], w[2:0]};
		d.cycles = CYC_ONE;
		if (w == 16'h0000) begin
			d.op = op_nop;
		end else if (w[15:8] == 8'h01) begin
			d.op = op_pair;
			d.rd = {w[7:4], 1'b0};
			d.rr = {w[3:0], 1'b0};
		end else if (w[15:10] == 6'h0b) begin
			d.op = op_mov;
		end else if (w[15:12] == 4'he) begin
			d.op = op_ldi;
			d.rd = {1'b1, w[7:4]};
		end else if (w[15:10] == 6'h3e && !w[3]) begin
			d.op = w[9] ? op_to_tflag : op_from_tflag;
		end else if (w[15:12] == 4'hb) begin
			d.op = w[11] ? op_out : op_in;
		end else if (w[15:9] == 7'h4a) begin
			case (w[3:0])
				4'h5: d.op = op_sshr;
				4'h2: d.op = op_swap;
				4'h8: begin
					if (!w[8]) begin
						d.op = op_flag;
						d.bit_sel = w[6:4];
						d.setv = ~w[7];
					end else begin
						case (w[7:4])
							4'h8: d.op = op_sleep;
							4'h9: d.op = op_break;
							4'ha: d.op = op_wdog;
							4'hc: begin
								d.op = op_code;
								d.rd = 5'h00;
								d.ptr = PTR_Z;
								d.cycles = CYC_THREE;
							end
							default: d.op = op_bad;
						endcase
					end
				end
				default: d.op = op_bad;
			endcase
		end else if (w[15:10] == 6'h24) begin
			d.op = w[9] ? op_store : op_load;
			d.cycles = CYC_TWO;
			// low opcode bits here select the mode, not an offset
			d.disp = 6'h00;
			case (w[3:0])
				4'h0: d.abs = 1'b1;
				4'h1: {d.ptr, d.inc} = {PTR_Z, 1'b1};
				4'h2: {d.ptr, d.dec} = {PTR_Z, 1'b1};
				4'h9: {d.ptr, d.inc} = {PTR_Y, 1'b1};
				4'ha: {d.ptr, d.dec} = {PTR_Y, 1'b1};
				4'hc: d.ptr = PTR_X;
				4'hd: {d.ptr, d.inc} = {PTR_X, 1'b1};
				4'he: {d.ptr, d.dec} = {PTR_X, 1'b1};
				4'h4, 4'h5: begin
					d.op = w[9] ? op_bad : op_code;
					{d.ptr, d.inc} = {PTR_Z, w[0]};
					d.cycles = CYC_THREE;
				end
				4'hf: d.op = w[9] ? op_push : op_pop;
				default: d.op = op_bad;
			endcase
		end else if (w[15:14] == 2'h2 && !w[12]) begin
			d.op = w[9] ? op_store : op_load;
			d.ptr = w[3] ? PTR_Y : PTR_Z;
			d.cycles = CYC_TWO;
		end
		decode = d;
	endfunction

	assign dec = decode(insn);

	////////////////////////////////////////////////////////////////////////
	// execution datapath
	logic run;
	logic [15:0] ptrv, ea, soff, code_word;
	logic [7:0] rd_val, rr_val, load_val, shr_val;
	logic wa_en, wp_en, io_we, sram_we;
	logic [4:0] wa_idx, wp_idx;
	logic [7:0] wa_data, store_data;
	logic [15:0] wp_data;
	logic tbit;

	assign run = (state == ex_run);
	assign ptrv = {rf[ptr_base(dec.ptr) + 5'h1], rf[ptr_base(dec.ptr)]};
	assign rd_val = rf[dec.rd];
	assign rr_val = rf[dec.rr];
	assign tbit = rd_val[dec.bit_sel];
	assign shr_val = {rd_val[7], rd_val[7:1]};
	assign soff = ea - IO_TOP;
	assign code_word = cmem[ptrv[CW:1]];

	always_comb begin
		if (dec.op == op_push) begin
			ea = sp;
		end else if (dec.op == op_pop) begin
			ea = sp + 16'h1;
		end else if (dec.op == op_in || dec.op == op_out) begin
			ea = REG_TOP + {10'h000, dec.io};
		end else if (dec.abs) begin
			ea = operand;
		end else if (dec.dec) begin
			ea = ptrv - 16'h1;
		end else if (dec.inc || dec.op == op_code) begin
			ea = ptrv;
		end else begin
			ea = ptrv + {10'h000, dec.disp};
		end
		if (ea < REG_TOP) begin
			load_val = rf[ea[4:0]];
		end else if (ea < IO_TOP) begin
			load_val = io_mem[ea[5:0] - 6'h20];
		end else begin
			load_val = sram[soff[DW-1:0]];
		end
	end

	always_comb begin
		wa_en = 1'b0;
		wa_idx = dec.rd;
		wa_data = 8'h00;
		wp_en = 1'b0;
		wp_idx = ptr_base(dec.ptr);
		wp_data = ptrv;
		io_we = 1'b0;
		sram_we = 1'b0;
		store_data = rd_val;
		if (run) begin
			case (dec.op)
				op_sshr: {wa_en, wa_data} = {1'b1, shr_val};
				op_swap: {wa_en, wa_data} = {1'b1, rd_val[3:0], rd_val[7:4]};
				op_from_tflag: begin
					wa_en = 1'b1;
					wa_data = rd_val;
					wa_data[dec.bit_sel] = flags[FLAG_T];
				end
				op_mov: {wa_en, wa_data} = {1'b1, rr_val};
				op_ldi: {wa_en, wa_data} = {1'b1, dec.imm};
				op_pair: begin
					wp_en = 1'b1;
					wp_idx = dec.rd;
					wp_data = {rf[dec.rr + 5'h1], rr_val};
				end
				op_load, op_pop, op_in: {wa_en, wa_data} = {1'b1, load_val};
				op_code: begin
					wa_en = 1'b1;
					wa_data = ptrv[0] ? code_word[15:8] : code_word[7:0];
				end
				op_store, op_push, op_out: begin
					wa_en = (ea < REG_TOP);
					wa_idx = ea[4:0];
					wa_data = store_data;
					io_we = (ea >= REG_TOP) && (ea < IO_TOP);
					sram_we = (ea >= IO_TOP);
				end
				default: wa_en = 1'b0;
			endcase
			if ((dec.inc || dec.dec) && dec.op != op_pair) begin
				wp_en = 1'b1;
				wp_data = dec.inc ? ptrv + 16'h1 : ptrv - 16'h1;
			end
		end
	end

	// pointer update written last so it wins if the destination overlaps it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 32; i++) begin
				rf[i] <= 8'h00;
			end
		end else begin
			if (wa_en) begin
				rf[wa_idx] <= wa_data;
			end
			if (wp_en) begin
				rf[wp_idx] <= wp_data[7:0];
				rf[wp_idx + 5'h1] <= wp_data[15:8];
			end
		end
	end

	// plain storage: no reset, like the on-chip memories it stands for
	always_ff @(posedge clk) begin
		if (io_we) begin
			io_mem[ea[5:0] - 6'h20] <= store_data;
		end
		if (sram_we) begin
			sram[soff[DW-1:0]] <= store_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus slave
	logic wr_take, rd_take, insn_ok;
	assign wr_take = awready && awvalid && wvalid;
	assign rd_take = arready && arvalid;
	assign insn_ok = (state == ex_idle);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready <= awvalid && wvalid && !awready && !bvalid;
			if (wr_take) begin
				bvalid <= 1'b1;
				case (awaddr)
					OFF_OPERAND, OFF_REG_SEL, OFF_CODE_LOAD: bresp <= RESP_OKAY;
					OFF_INSN, OFF_STATUS, OFF_STACK_PTR: bresp <= insn_ok ? RESP_OKAY : RESP_SLVERR;
					default: bresp <= RESP_SLVERR;
				endcase
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			operand <= 16'h0000;
			reg_sel <= 5'h00;
		end else if (wr_take) begin
			if (awaddr == OFF_OPERAND && wstrb[0]) begin
				operand[7:0] <= wdata[7:0];
			end
			if (awaddr == OFF_OPERAND && wstrb[1]) begin
				operand[15:8] <= wdata[15:8];
			end
			if (awaddr == OFF_REG_SEL && wstrb[0]) begin
				reg_sel <= wdata[4:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wr_take && awaddr == OFF_CODE_LOAD && wstrb == 4'hf) begin
			cmem[wdata[CW+15:16]] <= wdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (rd_take) begin
				rvalid <= 1'b1;
				rresp <= RESP_OKAY;
				case (araddr)
					OFF_OPERAND: rdata <= {16'h0000, operand};
					OFF_INSN: rdata <= {16'h0000, insn};
					OFF_STATUS: rdata <= {21'h000000, illegal, sleeping, !insn_ok, flags};
					OFF_REG_SEL: rdata <= {27'h0000000, reg_sel};
					OFF_REG_DATA: rdata <= {24'h000000, rf[reg_sel]};
					OFF_STACK_PTR: rdata <= {16'h0000, sp};
					OFF_CODE_LOAD: rdata <= 32'h0000_0000;
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= RESP_SLVERR;
					end
				endcase
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: one run edge applies the effect, hold edges pad the count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ex_idle;
			cnt <= 2'h0;
			insn <= 16'h0000;
		end else begin
			case (state)
				ex_idle: begin
					if (wr_take && awaddr == OFF_INSN) begin
						insn <= wdata[15:0];
						state <= ex_run;
					end
				end
				ex_run: begin
					cnt <= dec.cycles - 2'h1;
					state <= (dec.cycles == CYC_ONE) ? ex_idle : ex_hold;
				end
				ex_hold: begin
					cnt <= cnt - 2'h1;
					if (cnt == 2'h1) begin
						state <= ex_idle;
					end
				end
				default: state <= ex_idle;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags <= FLAGS_RESET;
		end else if (wr_take && awaddr == OFF_STATUS && insn_ok && wstrb[0]) begin
			flags <= wdata[7:0];
		end else if (run && dec.op == op_flag) begin
			flags[dec.bit_sel] <= dec.setv;
		end else if (run && dec.op == op_to_tflag) begin
			flags[FLAG_T] <= tbit;
		end else if (run && dec.op == op_sshr) begin
			flags[FLAG_C] <= rd_val[0];
			flags[FLAG_Z] <= (shr_val == 8'h00);
			flags[FLAG_N] <= shr_val[7];
			flags[FLAG_V] <= shr_val[7] ^ rd_val[0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sp <= SP_RESET;
		end else if (wr_take && awaddr == OFF_STACK_PTR && insn_ok) begin
			sp <= wdata[15:0];
		end else if (run && dec.op == op_push) begin
			sp <= sp - 16'h1;
		end else if (run && dec.op == op_pop) begin
			sp <= sp + 16'h1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sleep_pulse <= 1'b0;
			wdt_restart <= 1'b0;
			debug_break <= 1'b0;
			sleeping <= 1'b0;
			illegal <= 1'b0;
		end else begin
			sleep_pulse <= run && dec.op == op_sleep;
			wdt_restart <= run && dec.op == op_wdog;
			debug_break <= run && dec.op == op_break;
			if (run) begin
				sleeping <= (dec.op == op_sleep);
				illegal <= (dec.op == op_bad);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	AST_BIT_TO_T: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_to_tflag |=> flags == (($past(flags) & 8'hbf) | {1'b0, $past(tbit), 6'h00})
		&& state == ex_idle) else $error("bit store result wrong");
	AST_T_TO_BIT: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_from_tflag |=> $stable(flags) && rd_val[dec.bit_sel] == flags[FLAG_T])
		else $error("bit load result wrong");
	AST_OVF_OP: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_flag && dec.bit_sel == 3'(FLAG_V) |=> flags[FLAG_V] == $past(dec.setv)
		&& (flags & 8'hf7) == ($past(flags) & 8'hf7)) else $error("overflow op wrong");
	AST_HALF_OP: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_flag && dec.bit_sel == 3'(FLAG_H) |=> flags[FLAG_H] == $past(dec.setv)
		&& (flags & 8'hdf) == ($past(flags) & 8'hdf)) else $error("half carry op wrong");
	AST_SIGN_OP: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_flag && dec.bit_sel == 3'(FLAG_S) |=> flags[FLAG_S] == $past(dec.setv)
		&& state == ex_idle) else $error("sign flag op wrong");
	AST_POST_INC: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_load && dec.inc |=> ptrv == $past(ptrv) + 16'h1 ##1 state == ex_idle)
		else $error("post increment wrong");
	AST_PRE_DEC: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_store && dec.dec |=> ptrv == $past(ptrv) - 16'h1 && $stable(flags))
		else $error("pre decrement wrong");
	AST_TWO_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
		run && (dec.op == op_load || dec.op == op_store) |=> state == ex_hold ##1 state == ex_idle)
		else $error("transfer not two cycles");
	AST_CODE_READ: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_code |=> state == ex_hold [*2] ##1 state == ex_idle)
		else $error("code read not three cycles");
	AST_STACK: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_push |=> sp == $past(sp) - 16'h1 && $stable(flags))
		else $error("push wrong");
	AST_SLEEP: assert property (@(posedge clk) disable iff (!nrst)
		run && dec.op == op_sleep |=> sleep_pulse && sleeping && state == ex_idle)
		else $error("sleep wrong");
	AST_WDOG_RESTART: assert property (@(posedge clk) disable iff (!nrst)
		wdt_restart |-> $past(run) && $stable(flags)) else $error("watchdog restart wrong");
endmodule // btc_core
`default_nettype wire

// ---- btc_watch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// stands in for the power, watchdog and debug units fed by the core's pulses
module btc_watch_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sleep_pulse,
	input wire logic wdt_restart,
	input wire logic debug_break,
	output logic [7:0] sleep_cnt,
	output logic [7:0] wdt_cnt,
	output logic [7:0] brk_cnt
);
	////////////////////////////////////////////////////////////////
	// one count per pulse; a stuck pulse shows up as an inflated count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sleep_cnt <= 8'h00;
		end else if (sleep_pulse) begin
			sleep_cnt <= sleep_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdt_cnt <= 8'h00;
		end else if (wdt_restart) begin
			wdt_cnt <= wdt_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brk_cnt <= 8'h00;
		end else if (debug_break) begin
			brk_cnt <= brk_cnt + 8'h01;
		end
	end
endmodule // btc_watch_model
`default_nettype wire

// ---- mcu_bit_transfer_control_ops_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module mcu_bit_transfer_control_ops_test;
	import btc_pkg::*;
	typedef struct packed {
		logic [15:0] insn;
		logic [15:0] opnd;
		logic [4:0] sel;
		logic [7:0] val;
		logic [7:0] fl;
	} btc_row_t;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, sleep_pulse, wdt_restart, debug_break;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [7:0] sleep_cnt, wdt_cnt, brk_cnt;
	int num_errors = 0;
	int cmp_count = 0;
	// ordinary cases run in order; each row leaves state the next rows build on
	btc_row_t rows [40] = '{
		'{16'he801, 16'h0, 5'd16, 8'h81, 8'h00}, '{16'h9438, 16'h0, 5'd16, 8'h81, 8'h08},
		'{16'h9458, 16'h0, 5'd16, 8'h81, 8'h28}, '{16'h9448, 16'h0, 5'd16, 8'h81, 8'h38},
		'{16'h94b8, 16'h0, 5'd16, 8'h81, 8'h30}, '{16'h94d8, 16'h0, 5'd16, 8'h81, 8'h10},
		'{16'h94c8, 16'h0, 5'd16, 8'h81, 8'h00}, '{16'hfb07, 16'h0, 5'd16, 8'h81, 8'h40},
		'{16'hf913, 16'h0, 5'd17, 8'h08, 8'h40}, '{16'h9505, 16'h0, 5'd16, 8'hc0, 8'h45},
		'{16'h9502, 16'h0, 5'd16, 8'h0c, 8'h45}, '{16'he7a0, 16'h0, 5'd26, 8'h70, 8'h45},
		'{16'he0b0, 16'h0, 5'd27, 8'h00, 8'h45}, '{16'h930d, 16'h0, 5'd26, 8'h71, 8'h45},
		'{16'h931e, 16'h0, 5'd26, 8'h70, 8'h45}, '{16'h912d, 16'h0, 5'd18, 8'h08, 8'h45},
		'{16'h913e, 16'h0, 5'd19, 8'h08, 8'h45}, '{16'he6ce, 16'h0, 5'd28, 8'h6e, 8'h45},
		'{16'he0d0, 16'h0, 5'd29, 8'h00, 8'h45}, '{16'h830a, 16'h0, 5'd28, 8'h6e, 8'h45},
		'{16'h814a, 16'h0, 5'd20, 8'h0c, 8'h45}, '{16'h9310, 16'h71, 5'd17, 8'h08, 8'h45},
		'{16'h9150, 16'h71, 5'd21, 8'h08, 8'h45}, '{16'he7e2, 16'h0, 5'd30, 8'h72, 8'h45},
		'{16'he0f0, 16'h0, 5'd31, 8'h00, 8'h45}, '{16'h9301, 16'h0, 5'd30, 8'h73, 8'h45},
		'{16'h9172, 16'h0, 5'd23, 8'h0c, 8'h45}, '{16'h9195, 16'h0, 5'd25, 8'hef, 8'h45},
		'{16'h95c8, 16'h0, 5'd0, 8'hbe, 8'h45}, '{16'h930f, 16'h0, 5'd16, 8'h0c, 8'h45},
		'{16'h918f, 16'h0, 5'd24, 8'h0c, 8'h45}, '{16'hb915, 16'h0, 5'd17, 8'h08, 8'h45},
		'{16'hb165, 16'h0, 5'd22, 8'h08, 8'h45}, '{16'h011c, 16'h0, 5'd3, 8'hef, 8'h45},
		'{16'h904c, 16'h0, 5'd4, 8'h0c, 8'h45}, '{16'h2c53, 16'h0, 5'd5, 8'hef, 8'h45},
		'{16'h0000, 16'h0, 5'd5, 8'hef, 8'h45},
		'{16'h95a8, 16'h0, 5'd3, 8'hef, 8'h45}, '{16'h9598, 16'h0, 5'd3, 8'hef, 8'h45},
		'{16'h9588, 16'h0, 5'd3, 8'hef, 8'h45}
	};

	btc_core u_btc_core (.clk(clk), .nrst(nrst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .sleep_pulse(sleep_pulse),
		.wdt_restart(wdt_restart), .debug_break(debug_break));

	btc_watch_model u_btc_watch_model (.clk(clk), .nrst(nrst), .sleep_pulse(sleep_pulse),
		.wdt_restart(wdt_restart), .debug_break(debug_break), .sleep_cnt(sleep_cnt), .wdt_cnt(wdt_cnt),
		.brk_cnt(brk_cnt));

	initial begin
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// address and data go out together; a silent slave ends the wait as a mismatch
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1'b1;
		do begin @(posedge clk); n++; end while (awready !== 1'b1 && n < 200);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 200);
		r = bresp;
		bready <= 1'b0;
		if (n >= 200) num_errors++;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 200);
		arvalid <= 1'b0;
		do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 200);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 200) num_errors++;
	endtask

	// busy must drop before the next opcode may be written
	task automatic exec(input logic [15:0] op);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		axi_wr(OFF_INSN, {16'h0, op}, r);
		n = 0;
		do begin axi_rd(OFF_STATUS, d, r); n++; end while (d[8] !== 1'b0 && n < 50);
		if (n >= 50) num_errors++;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		num_errors++;
		final_report();
	end

	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		axi_rd(OFF_STATUS, rd, resp);
		check_val(rd, 32'h0);
		check_val({30'h0, resp}, {30'h0, RESP_OKAY});
		axi_rd(OFF_STACK_PTR, rd, resp);
		check_val(rd, {16'h0, SP_RESET});
		axi_wr(OFF_CODE_LOAD, 32'h0039beef, resp);
		foreach (rows[i]) begin
			axi_wr(OFF_OPERAND, {16'h0, rows[i].opnd}, resp);
			exec(rows[i].insn);
			axi_wr(OFF_REG_SEL, {27'h0, rows[i].sel}, resp);
			axi_rd(OFF_REG_DATA, rd, resp);
			check_val({24'h0, rd[7:0]}, {24'h0, rows[i].val});
			axi_rd(OFF_STATUS, rd, resp);
			check_val({24'h0, rd[7:0]}, {24'h0, rows[i].fl});
		end
		check_val({30'h0, rd[9:8]}, 32'h2);
		check_val({8'h0, sleep_cnt, wdt_cnt, brk_cnt}, 32'h010101);
		// unknown opcode flags itself and ends the sleep mark; flags survive it
		exec(16'hffff);
		axi_rd(OFF_STATUS, rd, resp);
		check_val(rd, 32'h0000_0445);
		axi_wr(OFF_STATUS, 32'h0000_00a5, resp);
		axi_rd(OFF_STATUS, rd, resp);
		check_val(rd, 32'h0000_04a5);
		axi_rd(OFF_STACK_PTR, rd, resp);
		check_val(rd, {16'h0, SP_RESET});
		// unmapped places and the write-only loader
		axi_rd(8'h1c, rd, resp);
		check_val({rd[29:0], resp}, {30'h0, RESP_SLVERR});
		axi_wr(8'h20, 32'h0, resp);
		check_val({30'h0, resp}, {30'h0, RESP_SLVERR});
		axi_rd(OFF_CODE_LOAD, rd, resp);
		check_val(rd, 32'h0);
		// second reset in mid-run clears registers and status
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		axi_rd(OFF_REG_DATA, rd, resp);
		check_val(rd, 32'h0);
		axi_rd(OFF_STATUS, rd, resp);
		check_val(rd, 32'h0);
		final_report();
	end
endmodule // mcu_bit_transfer_control_ops_test
`default_nettype wire
